// >>> logic/ldc_pkg.sv
// Constants, types and helper functions of the LED driver configuration register slice.
// Operation
// [R1] Frequency select codes 00..11 mean 200k, 400k, 1M, 2.2M; reset code is 01.
// [R2] String select 000-010 all four strings, 011 three, 100 two, 101 one.
// [R3] Host never writes string select codes 110 or 111.
// [R4] Fault register bit 7 enables all LED short protections; resets to 0.
// [R5] Fault register bit 6 switches the whole device off; resets to 0.
// [R6] Fault flags set on a fault and hold until read back or reset.
// [R7] Bit 5 captures an LED string pin short to ground.
// [R8] Bit 4 captures an over-temperature protection event.
// [R9] Bit 3 captures an output under-voltage protection event.
// [R10] Bit 2 captures an over-current protection event; resets to 0.
// [R11] Bit 1 captures an LED current source short; resets to 0.
// [R12] Bit 0 captures an LED current source open; resets to 0.
// [R13] Host leaves the frequency-set pin floating when using the register frequency.
// [R14] Frequency and string register sits at 0x01 with phase shift and threshold bits.
// [R15] Device answers 7-bit address 0x38 to 0x3A chosen by the address select pin.
// [R16] Access is address, register byte, then data or repeated start; unused bits read zero.
package ldc_pkg;
    localparam logic [7:0] ADDR_FSW_STR = 8'h01;
    localparam logic [7:0] ADDR_FAULT = 8'h02;
    localparam logic [7:0] ADDR_PART = 8'h03;
    localparam int PSE_BIT = 7;
    localparam int TH_LSB = 5;
    localparam int FSW_LSB = 3;
    localparam int STR_LSB = 0;
    localparam int SEN_BIT = 7;
    localparam int OFF_BIT = 6;
    localparam int FLAG_W = 6;
    localparam logic [7:0] FSW_STR_RST = 8'h28;
    localparam logic [1:0] FAULT_CTL_RST = 2'h0;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [6:0] I2C_BASE_ADDR = 7'h38;
    localparam logic [6:0] I2C_TOP_ADDR = 7'h3A;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        FSW_200K = 2'h0,
        FSW_400K = 2'h1,
        FSW_1M = 2'h2,
        FSW_2M2 = 2'h3
    } ldc_fsw_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEV = 7'h02,
        ST_ACK = 7'h04,
        ST_REG = 7'h08,
        ST_WR = 7'h10,
        ST_RD = 7'h20,
        ST_MACK = 7'h40
    } ldc_state_t;

    typedef struct packed {
        logic string_gnd_short;
        logic overtemp;
        logic undervolt;
        logic overcurrent;
        logic source_short;
        logic source_open;
    } ldc_fault_t;

    typedef struct packed {
        logic phase_shift_enable;
        logic [1:0] short_threshold_sel;
        ldc_fsw_t switch_freq_sel;
        logic [3:0] string_en;
        logic short_prot_enable;
        logic device_off;
    } ldc_cfg_t;

    // Reserved codes turn every string off, the safest answer to an undefined setting.
    function automatic logic [3:0] ldc_string_en(input logic [2:0] sel);
        logic [3:0] en;
        en = 4'h0;
        if (sel <= 3'h2)
            en = 4'hF;
        else if (sel == 3'h3)
            en = 4'h7;
        else if (sel == 3'h4)
            en = 4'h3;
        else if (sel == 3'h5)
            en = 4'h1;
        return en;
    endfunction : ldc_string_en

    function automatic logic [6:0] ldc_dev_addr(input logic [1:0] sel);
        logic [6:0] a;
        a = I2C_TOP_ADDR;
        if (sel == 2'h0)
            a = I2C_BASE_ADDR;
        else if (sel == 2'h1)
            a = I2C_BASE_ADDR + 7'h01;
        return a;
    endfunction : ldc_dev_addr
endpackage : ldc_pkg

// >>> logic/ldc_fault_flags.sv
// Sticky fault flags that clear on readback, with set winning over clear.
`timescale 1ns/1ps
module ldc_fault_flags #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] set,
    input wire logic clr,
    output logic [W-1:0] flags
);
    import ldc_pkg::*;

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // An event in the readback cycle survives so that no fault goes unreported.
    always_comb
    begin
        flags_nxt = flags_r;
        if (clr)
            flags_nxt = '0;
        flags_nxt = flags_nxt | set; // [R6]
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            flags_r <= W'(FLAGS_RST);
        else
            flags_r <= flags_nxt;
    end

    assign flags = flags_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_hold;
        !clr |=> ((flags_r & $past(flags_r)) == $past(flags_r));
    endproperty
    a_hold: assert property (p_hold) else $error("fault flag dropped without readback"); // [R6]

    property p_capture;
        (set != '0) |=> ((flags_r & $past(set)) == $past(set));
    endproperty
    a_capture: assert property (p_capture) else $error("fault event not captured"); // [R7]

    property p_clear;
        (clr && set == '0) |=> (flags_r == '0) ##1 (flags_r == $past(set));
    endproperty
    a_clear: assert property (p_clear) else $error("readback did not clear flags"); // [R6]
endmodule : ldc_fault_flags

// >>> logic/ldc_regs.sv
// I2C-reached configuration and fault register slice of the LED driver.
`timescale 1ns/1ps
module ldc_regs #(
    parameter logic [5:0] PART_CODE = 6'h15
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_sel,
    input ldc_pkg::ldc_fault_t fault_in,
    output ldc_pkg::ldc_cfg_t cfg,
    output ldc_pkg::ldc_fault_t fault_flags
);
    import ldc_pkg::*;

    // PART_CODE default is arbitrary and names no real part.
    ldc_state_t state_r, state_nxt, ret_r, ret_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, addr_r, addr_nxt;
    logic drv_r, drv_nxt, scl_q_r, sda_q_r;
    logic [7:0] fsw_str_r, fsw_str_nxt;
    logic [1:0] ctl_r, ctl_nxt;
    logic scl_rise, scl_fall, start, stop, wr_stb, rd_ld, clr;
    logic [7:0] rd_byte;
    logic [5:0] flags;
    logic [6:0] dev_addr;

    assign scl_rise = scl_in & ~scl_q_r;
    assign scl_fall = ~scl_in & scl_q_r;
    assign start = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign stop = scl_in & scl_q_r & ~sda_q_r & sda_in;
    assign dev_addr = ldc_dev_addr(addr_sel); // [R15]

    // Unmapped addresses and reserved bits read as zero.
    always_comb
    begin
        rd_byte = 8'h00;
        if (addr_r == ADDR_FSW_STR)
            rd_byte = fsw_str_r; // [R14]
        else if (addr_r == ADDR_FAULT)
            rd_byte = {ctl_r, flags};
        else if (addr_r == ADDR_PART)
            rd_byte = {2'h0, PART_CODE}; // [R16]
    end

    always_comb
    begin
        state_nxt = state_r;
        ret_nxt = ret_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        drv_nxt = drv_r;
        wr_stb = 1'b0;
        rd_ld = 1'b0;
        if (start)
        begin
            state_nxt = ST_DEV; // [R16]
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end
        else if (stop)
        begin
            state_nxt = ST_IDLE;
            drv_nxt = 1'b0;
        end
        else
        begin
            if ((state_r == ST_DEV || state_r == ST_REG || state_r == ST_WR) && scl_rise)
            begin
                sh_nxt = {sh_r[6:0], sda_in};
                cnt_nxt = 4'(cnt_r + 4'h1);
            end
            case (state_r)
                ST_DEV:
                    if (scl_fall && cnt_r == BITS_PER_BYTE)
                    begin
                        if (sh_r[7:1] == dev_addr) // [R15]
                        begin
                            state_nxt = ST_ACK;
                            drv_nxt = 1'b1;
                            ret_nxt = sh_r[0] ? ST_RD : ST_REG;
                        end
                        else
                            state_nxt = ST_IDLE;
                    end
                ST_REG:
                    if (scl_fall && cnt_r == BITS_PER_BYTE)
                    begin
                        addr_nxt = sh_r; // [R16]
                        state_nxt = ST_ACK;
                        drv_nxt = 1'b1;
                        ret_nxt = ST_WR;
                    end
                ST_WR:
                    if (scl_fall && cnt_r == BITS_PER_BYTE)
                    begin
                        wr_stb = 1'b1;
                        addr_nxt = 8'(addr_r + 8'h01);
                        state_nxt = ST_ACK;
                        drv_nxt = 1'b1;
                        ret_nxt = ST_WR;
                    end
                ST_ACK:
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        state_nxt = ret_r;
                        drv_nxt = 1'b0;
                        if (ret_r == ST_RD)
                        begin
                            rd_ld = 1'b1;
                            tx_nxt = rd_byte;
                            drv_nxt = ~rd_byte[7];
                        end
                    end
                ST_RD:
                begin
                    if (scl_rise)
                        cnt_nxt = 4'(cnt_r + 4'h1);
                    if (scl_fall)
                    begin
                        if (cnt_r == BITS_PER_BYTE)
                        begin
                            drv_nxt = 1'b0;
                            state_nxt = ST_MACK;
                        end
                        else
                        begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            drv_nxt = ~tx_r[6];
                        end
                    end
                end
                ST_MACK:
                    if (scl_rise)
                    begin
                        if (sda_in)
                            state_nxt = ST_IDLE;
                        else
                        begin
                            state_nxt = ST_ACK;
                            ret_nxt = ST_RD;
                            addr_nxt = 8'(addr_r + 8'h01);
                        end
                    end
                default:
                    state_nxt = ST_IDLE;
            endcase
        end
    end

    // Readback clears the flags at the moment the byte is captured for shifting out.
    assign clr = rd_ld && (addr_r == ADDR_FAULT); // [R6]

    always_comb
    begin
        fsw_str_nxt = fsw_str_r;
        ctl_nxt = ctl_r;
        if (wr_stb && addr_r == ADDR_FSW_STR)
            fsw_str_nxt = sh_r; // [R14]
        else if (wr_stb && addr_r == ADDR_FAULT)
            ctl_nxt = {sh_r[SEN_BIT], sh_r[OFF_BIT]}; // [R4] [R5]
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            ret_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= 8'h00;
            drv_r <= 1'b0;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            fsw_str_r <= FSW_STR_RST; // [R1]
            ctl_r <= FAULT_CTL_RST; // [R4] [R5]
        end
        else
        begin
            state_r <= state_nxt;
            ret_r <= ret_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            drv_r <= drv_nxt;
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            fsw_str_r <= fsw_str_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    ldc_fault_flags #(
        .W(FLAG_W)
    ) u_flags (
        .clk(clk),
        .nrst(nrst),
        .set(fault_in), // [R7] [R8] [R9] [R10] [R11] [R12]
        .clr(clr),
        .flags(flags)
    );

    // Open drain: the pin is only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = drv_r;
    assign fault_flags = flags;
    assign cfg.phase_shift_enable = fsw_str_r[PSE_BIT];
    assign cfg.short_threshold_sel = fsw_str_r[TH_LSB +: 2];
    assign cfg.switch_freq_sel = ldc_fsw_t'(fsw_str_r[FSW_LSB +: 2]); // [R1]
    assign cfg.string_en = ldc_string_en(fsw_str_r[STR_LSB +: 3]); // [R2]
    assign cfg.short_prot_enable = ctl_r[1]; // [R4]
    assign cfg.device_off = ctl_r[0]; // [R5]

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_freq_rst;
        $rose(nrst) |-> (cfg.switch_freq_sel == FSW_400K && cfg.string_en == 4'hF);
    endproperty
    a_freq_rst: assert property (p_freq_rst) else $error("bad frequency reset"); // [R1]

    property p_one_string;
        (fsw_str_r[2:0] == 3'h5) |-> (cfg.string_en == 4'h1);
    endproperty
    a_one_string: assert property (p_one_string) else $error("bad string decode"); // [R2]

    property p_sen_wr;
        (wr_stb && addr_r == ADDR_FAULT) |=> (cfg.short_prot_enable == $past(sh_r[7]));
    endproperty
    a_sen_wr: assert property (p_sen_wr) else $error("short enable not written"); // [R4]

    property p_off_wr;
        (wr_stb && addr_r == ADDR_FAULT) |=> (cfg.device_off == $past(sh_r[6]))
            ##1 $stable(cfg.device_off);
    endproperty
    a_off_wr: assert property (p_off_wr) else $error("device off not written"); // [R5]

    property p_rd_fsw;
        (rd_ld && addr_r == ADDR_FSW_STR) |=> (tx_r == fsw_str_r);
    endproperty
    a_rd_fsw: assert property (p_rd_fsw) else $error("register 0x01 read wrong"); // [R14]

    property p_dev_ack;
        (state_r == ST_DEV && state_nxt == ST_ACK) |=> (sda_oe && sh_r[7:1] >= I2C_BASE_ADDR
            && sh_r[7:1] <= I2C_TOP_ADDR);
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("acked foreign address"); // [R15]

    property p_unmapped;
        (rd_ld && addr_r > ADDR_PART) |=> (tx_r == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R16]

    property p_part_rsvd;
        (rd_ld && addr_r == ADDR_PART) |=> (tx_r[7:6] == 2'h0);
    endproperty
    a_part_rsvd: assert property (p_part_rsvd) else $error("reserved bits not zero"); // [R16]

    c_write: cover property (wr_stb && addr_r == ADDR_FSW_STR);
    c_fault_rd: cover property (clr && flags != 6'h00);
    c_nack: cover property (state_r == ST_MACK && scl_rise && sda_in);
    c_burst_rd: cover property (state_r == ST_MACK && scl_rise && !sda_in);
endmodule : ldc_regs

// >>> verification/ldc_i2c_host.sv
// Behavioural I2C host that drives the clock and data wires of the register slice.
`timescale 1ns/1ps
module ldc_i2c_host (
    input wire logic clk,
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda_in
);
    // Four cycles a phase keeps a margin over the two the slave needs.
    localparam int PH = 4;
    logic sda_h = 1'b1;
    initial scl = 1'b1;
    // The wire has a pull-up, so a released line reads high.
    assign sda_in = (sda_oe === 1'b1) ? (sda_out & sda_h) : sda_h;

    task automatic wait_ph(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_ph

    task automatic start_c();
        sda_h <= 1'b1;
        wait_ph(PH / 2);
        scl <= 1'b1;
        wait_ph(PH);
        sda_h <= 1'b0;
        wait_ph(PH);
        scl <= 1'b0;
        wait_ph(PH / 2);
    endtask : start_c

    task automatic stop_c();
        sda_h <= 1'b0;
        wait_ph(PH);
        scl <= 1'b1;
        wait_ph(PH);
        sda_h <= 1'b1;
        wait_ph(PH);
    endtask : stop_c

    task automatic xfer_bit(input logic b, output logic r);
        wait_ph(1);
        sda_h <= b;
        wait_ph(PH);
        scl <= 1'b1;
        wait_ph(PH);
        r = sda_in;
        scl <= 1'b0;
    endtask : xfer_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(~mack, r);
    endtask : get_byte
endmodule : ldc_i2c_host

// >>> verification/led_driver_config_regs_tb.sv
// Self-checking bench of the LED driver configuration register slice.
`timescale 1ns/1ps
module led_driver_config_regs_tb;
    import ldc_pkg::*;
    // Arbitrary part code for this bench.
    localparam logic [5:0] CODE = 6'h2A;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, sda_in, sda_out, sda_oe;
    logic [1:0] addr_sel = 2'h0;
    logic [6:0] dev_addr = 7'h38;
    ldc_fault_t fault_in = '0;
    ldc_cfg_t cfg;
    ldc_fault_t fault_flags;
    logic [7:0] cfg_hi, ctl;
    int bad_count = 0;
    int samples_checked = 0;

    assign cfg_hi = {cfg.phase_shift_enable, cfg.short_threshold_sel, cfg.switch_freq_sel, 3'h0};
    assign ctl = {cfg.short_prot_enable, cfg.device_off, fault_flags};
    always #12.5 clk = ~clk;

    ldc_regs #(.PART_CODE(CODE)) i_dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .fault_in(fault_in),
        .cfg(cfg), .fault_flags(fault_flags));
    ldc_i2c_host i_host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl),
        .sda_in(sda_in));

    function automatic logic [3:0] exp_str(input logic [2:0] s);
        case (s)
            3'h3: return 4'h7;
            3'h4: return 4'h3;
            3'h5: return 4'h1;
            default: return 4'hF;
        endcase
    endfunction : exp_str

    function automatic logic [6:0] exp_dev(input logic [1:0] s);
        return (s == 2'h0) ? 7'h38 : ((s == 2'h1) ? 7'h39 : 7'h3A);
    endfunction : exp_dev

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ra, input logic [15:0] d,
                          input int n, output logic ack);
        logic a;
        i_host.start_c();
        i_host.send_byte({dev, 1'b0}, ack);
        if (ack)
        begin
            i_host.send_byte(ra, a);
            for (int i = n - 1; i >= 0; i--)
                i_host.send_byte(d[8*i +: 8], a);
        end
        i_host.stop_c();
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] ra, output logic [7:0] d);
        logic a;
        i_host.start_c();
        i_host.send_byte({dev_addr, 1'b0}, a);
        i_host.send_byte(ra, a);
        i_host.start_c();
        i_host.send_byte({dev_addr, 1'b1}, a);
        i_host.get_byte(1'b0, d);
        i_host.stop_c();
    endtask : reg_rd

    // The master acknowledges the first byte, so the slice must step on to the next register.
    task automatic reg_rd2(input logic [7:0] ra, output logic [15:0] d);
        logic a;
        i_host.start_c();
        i_host.send_byte({dev_addr, 1'b0}, a);
        i_host.send_byte(ra, a);
        i_host.start_c();
        i_host.send_byte({dev_addr, 1'b1}, a);
        i_host.get_byte(1'b1, d[15:8]);
        i_host.get_byte(1'b0, d[7:0]);
        i_host.stop_c();
    endtask : reg_rd2

    task automatic chk_reset();
        check(cfg_hi, 8'h28);
        check({4'h0, cfg.string_en}, 8'h0F);
        check(ctl, 8'h00);
    endtask : chk_reset

    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("FAIL t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] rd, v, w;
        logic [15:0] rd2;
        logic ack;
        void'($urandom(40));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk_reset();
        reg_rd(ADDR_FSW_STR, rd);
        check(rd, 8'h28);
        reg_rd(ADDR_PART, rd);
        check(rd, {2'h0, CODE});
        reg_rd(8'h05, rd);
        check(rd, 8'h00);
        // Host keeps to string codes 000 to 101 and sets the frequency through the register only.
        for (int i = 0; i < 8; i++)
        begin
            v = {1'($urandom), 2'($urandom), 2'(i), 3'(i % 6)};
            addr_sel <= 2'(i);
            dev_addr = exp_dev(2'(i));
            @(posedge clk);
            reg_wr(7'h3B, ADDR_FSW_STR, {8'h00, v}, 1, ack);
            check({7'h0, ack}, 8'h00);
            reg_wr(dev_addr, ADDR_FSW_STR, {8'h00, v}, 1, ack);
            check({7'h0, ack}, 8'h01);
            check(cfg_hi, {v[7:3], 3'h0});
            check({4'h0, cfg.string_en}, {4'h0, exp_str(v[2:0])});
            reg_rd(ADDR_FSW_STR, rd);
            check(rd, v);
        end
        // Two bytes in one transfer prove the address steps on, for writes and for reads.
        for (int k = 0; k < 4; k++)
        begin
            v = {3'($urandom), 2'(k), 3'(k)};
            w = {2'(k), 6'($urandom)};
            reg_wr(dev_addr, ADDR_FSW_STR, {v, w}, 2, ack);
            check(cfg_hi, {v[7:3], 3'h0});
            check(ctl, {w[7:6], 6'h00});
            reg_rd(ADDR_FAULT, rd);
            check(rd, {w[7:6], 6'h00});
            reg_rd2(ADDR_FSW_STR, rd2);
            check(rd2[15:8], v);
            check(rd2[7:0], {w[7:6], 6'h00});
        end
        reg_wr(dev_addr, ADDR_PART, 16'h00FF, 1, ack);
        reg_rd(ADDR_PART, rd);
        check(rd, {2'h0, CODE});
        for (int b = 0; b < 6; b++)
        begin
            fault_in <= ldc_fault_t'(6'h01 << b);
            @(posedge clk);
            fault_in <= '0;
            repeat (4) @(posedge clk);
            check({2'h0, fault_flags}, {2'h0, 6'h01 << b});
            reg_rd(ADDR_FAULT, rd);
            check(rd, {2'h3, 6'h01 << b});
            check({2'h0, fault_flags}, 8'h00);
        end
        // A fault still present during the readback must not be lost.
        fault_in <= ldc_fault_t'(6'h3F);
        repeat (2) @(posedge clk);
        reg_rd(ADDR_FAULT, rd);
        check(rd, 8'hFF);
        check({2'h0, fault_flags}, 8'h3F);
        fault_in <= '0;
        reg_rd(ADDR_FAULT, rd);
        check(rd, 8'hFF);
        check({2'h0, fault_flags}, 8'h00);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk_reset();
        tally_and_finish();
    end
endmodule : led_driver_config_regs_tb
